// File: pkg/pcra_pkg.sv
// Shared types and constants of the completer register-access block
package pcra_pkg;
    localparam int TDATA_W = 256;
    localparam int REG_W = 128;
    localparam int DESC_W = 128;
    localparam int CC_DESC_W = 96;
    localparam int BAR_W = 32;
    localparam int NUM_BARS = 3;
    localparam int NUM_REGS = 16;
    localparam int NUM_DESC = 8;
    localparam int REG_DWORDS = 4;
    localparam int DW_BITS = 5;
    localparam int REG_IDX_LSB = 4;
    localparam int REG_IDX_MSB = 7;
    localparam logic [BAR_W-1:0] REG_WINDOW = 32'h0000_0100;
    localparam logic [3:0] STATUS_IDX = 4'he;
    localparam logic [3:0] DESC_ENABLE_IDX = 4'hf;
    localparam logic [2:0] SLOW_DIV_LAST = 3'h5;
    localparam logic [10:0] MAX_DWORDS = 11'h004;
    localparam logic [7:0] CC_DESC_KEEP = 8'h07;
    localparam int CC_DESC_DWORDS = 3;

    localparam logic [3:0] REQ_MEM_RD = 4'h0;
    localparam logic [3:0] REQ_MEM_WR = 4'h1;
    localparam logic [3:0] REQ_IO_RD = 4'h2;
    localparam logic [3:0] REQ_IO_WR = 4'h3;

    localparam logic [2:0] CPL_SC = 3'h0;
    localparam logic [2:0] CPL_UR = 3'h1;
    localparam logic [2:0] CPL_CA = 3'h4;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_READ = 3'h1,
        ST_WR_FETCH = 3'h2,
        ST_MOD_WR = 3'h3,
        ST_WAIT = 3'h4,
        ST_ERR_CPL = 3'h5
    } pcra_state_e;

    typedef struct packed {
        logic rsvd127;
        logic [2:0] attr;
        logic [2:0] tclass;
        logic [5:0] bar_aperture;
        logic [2:0] bar_id;
        logic [7:0] target_func;
        logic [7:0] tag;
        logic [15:0] requester_id;
        logic rsvd79;
        logic [3:0] req_type;
        logic [10:0] dword_count;
        logic [61:0] addr;
        logic [1:0] addr_type;
    } pcra_cq_desc_s;

    typedef struct packed {
        logic force_ecrc;
        logic [2:0] attr;
        logic [2:0] tclass;
        logic cid_en;
        logic [15:0] completer_id;
        logic [7:0] tag;
        logic [15:0] requester_id;
        logic rsvd47;
        logic poisoned;
        logic [2:0] status;
        logic [10:0] dword_count;
        logic [1:0] rsvd31;
        logic locked;
        logic [12:0] byte_count;
        logic [5:0] rsvd15;
        logic [1:0] addr_type;
        logic rsvd7;
        logic [6:0] lower_addr;
    } pcra_cc_desc_s;

    typedef struct packed {
        logic [48:0] zero_hi;
        logic [3:0] req_type;
        logic [10:0] dword_count;
        logic [61:0] addr;
        logic [1:0] addr_type;
    } pcra_rq_desc_s;

    typedef struct packed {
        logic [52:0] hi;
        logic [10:0] dword_count;
        logic [31:0] lo;
    } pcra_rc_desc_s;

    typedef struct packed {
        logic write;
        logic [2:0] bar_id;
        logic [63:0] addr;
        logic [REG_W-1:0] wdata;
    } pcra_reg_req_s;
endpackage

// File: hdl/pcra_reg_map.sv
// Register map on the slow register strobe, with request and response synchronisers
`timescale 1ns/1ps
module pcra_reg_map (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic req_valid_i,
    input wire pcra_pkg::pcra_reg_req_s req_i,
    input wire logic [pcra_pkg::NUM_BARS-1:0][pcra_pkg::BAR_W-1:0] bar_i,
    input wire logic [pcra_pkg::NUM_DESC-1:0] desc_status_i,
    output logic done_o,
    output logic [pcra_pkg::REG_W-1:0] rdata_o,
    output logic [pcra_pkg::NUM_DESC-1:0] desc_enable_o
);
    logic [2:0] div_reg, div_next;
    logic tick;
    logic req_sync_reg, req_sync_next;
    pcra_pkg::pcra_reg_req_s req_slow_reg, req_slow_next;
    logic slow_done_reg, slow_done_next;
    logic [pcra_pkg::REG_W-1:0] slow_rdata_reg, slow_rdata_next;
    logic resp_done_reg, resp_done_next;
    logic [pcra_pkg::REG_W-1:0] resp_rdata_reg, resp_rdata_next;
    logic [pcra_pkg::REG_W-1:0] regs_reg [pcra_pkg::NUM_REGS];
    logic [pcra_pkg::REG_W-1:0] regs_next [pcra_pkg::NUM_REGS];
    logic [pcra_pkg::NUM_DESC-1:0] den_reg, den_next, den_slow_reg, den_slow_next;
    logic [4:0] slow_dec, fast_dec;

    // Returns {hit, index} of an address inside the window of the selected base
    function automatic logic [4:0] decode(input logic [63:0] a, input logic [2:0] b,
            input logic [pcra_pkg::NUM_BARS-1:0][pcra_pkg::BAR_W-1:0] bars);
        logic [pcra_pkg::BAR_W-1:0] off;
        off = '0;
        if (b < 3'(pcra_pkg::NUM_BARS)) begin
            off = a[pcra_pkg::BAR_W-1:0] - bars[b[1:0]];
        end
        return {(b < 3'(pcra_pkg::NUM_BARS)) && (off < pcra_pkg::REG_WINDOW),
                off[pcra_pkg::REG_IDX_MSB:pcra_pkg::REG_IDX_LSB]};
    endfunction

    assign tick = div_reg == pcra_pkg::SLOW_DIV_LAST;
    assign slow_dec = decode(req_slow_reg.addr, req_slow_reg.bar_id, bar_i);
    assign fast_dec = decode(req_i.addr, req_i.bar_id, bar_i);

    always_comb begin
        div_next = tick ? '0 : div_reg + 3'h1;
        req_sync_next = req_sync_reg;
        req_slow_next = req_slow_reg;
        slow_done_next = slow_done_reg;
        slow_rdata_next = slow_rdata_reg;
        regs_next = regs_reg;
        den_next = den_reg;
        den_slow_next = den_slow_reg;
        if (tick) begin
            req_sync_next = req_valid_i;
            req_slow_next = req_i;
            den_slow_next = den_reg;
            if (req_sync_reg && !slow_done_reg) begin
                slow_done_next = 1'b1;
                slow_rdata_next = '0;
                if (slow_dec[4]) begin
                    if (slow_dec[3:0] == pcra_pkg::STATUS_IDX) begin
                        slow_rdata_next = {{(pcra_pkg::REG_W-pcra_pkg::NUM_DESC){1'b0}},
                                           desc_status_i};
                    end else if (slow_dec[3:0] == pcra_pkg::DESC_ENABLE_IDX) begin
                        slow_rdata_next = {{(pcra_pkg::REG_W-pcra_pkg::NUM_DESC){1'b0}},
                                           den_slow_reg};
                    end else begin
                        slow_rdata_next = regs_reg[slow_dec[3:0]];
                        if (req_slow_reg.write) begin
                            regs_next[slow_dec[3:0]] = req_slow_reg.wdata;
                        end
                    end
                end
            end else if (!req_sync_reg) begin
                slow_done_next = 1'b0;
            end
        end
        // Descriptor enable is taken straight from the fast side request
        if (req_valid_i && req_i.write && fast_dec[4] &&
                fast_dec[3:0] == pcra_pkg::DESC_ENABLE_IDX) begin
            den_next = req_i.wdata[pcra_pkg::NUM_DESC-1:0];
        end
        resp_done_next = slow_done_reg;
        resp_rdata_next = slow_rdata_reg;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            div_reg <= '0;
            req_sync_reg <= 1'b0;
            req_slow_reg <= '0;
            slow_done_reg <= 1'b0;
            slow_rdata_reg <= '0;
            resp_done_reg <= 1'b0;
            resp_rdata_reg <= '0;
            regs_reg <= '{default: '0};
            den_reg <= '0;
            den_slow_reg <= '0;
        end else begin
            div_reg <= div_next;
            req_sync_reg <= req_sync_next;
            req_slow_reg <= req_slow_next;
            slow_done_reg <= slow_done_next;
            slow_rdata_reg <= slow_rdata_next;
            resp_done_reg <= resp_done_next;
            resp_rdata_reg <= resp_rdata_next;
            regs_reg <= regs_next;
            den_reg <= den_next;
            den_slow_reg <= den_slow_next;
        end
    end

    assign done_o = resp_done_reg;
    assign rdata_o = resp_rdata_reg;
    assign desc_enable_o = den_slow_reg;
endmodule

// File: hdl/pcra_dma_hdr.sv
// DMA request header builder, completion header stripper and descriptor status
`timescale 1ns/1ps
module pcra_dma_hdr (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic req_i,
    input wire logic write_i,
    input wire logic [63:0] addr_i,
    input wire logic [10:0] dwords_i,
    input wire logic [2:0] desc_i,
    input wire logic [pcra_pkg::NUM_DESC-1:0] enable_i,
    input wire logic rc_valid_i,
    input wire logic [pcra_pkg::CC_DESC_W-1:0] rc_hdr_i,
    input wire logic [2:0] rc_desc_i,
    output logic [pcra_pkg::DESC_W-1:0] rq_hdr_o,
    output logic [10:0] rc_dwords_o,
    output logic [pcra_pkg::NUM_DESC-1:0] status_o
);
    pcra_pkg::pcra_rq_desc_s hdr_reg, hdr_next;
    pcra_pkg::pcra_rc_desc_s rc_hdr;
    logic [10:0] rcdw_reg, rcdw_next;
    logic [pcra_pkg::NUM_DESC-1:0] stat_reg, stat_next, set_vec;

    assign rc_hdr = rc_hdr_i;

    genvar i;
    generate
        for (i = 0; i < pcra_pkg::NUM_DESC; i++) begin : g_set
            assign set_vec[i] = (req_i && write_i && desc_i == 3'(i)) ||
                                (rc_valid_i && rc_desc_i == 3'(i));
        end
    endgenerate

    always_comb begin
        hdr_next = hdr_reg;
        if (req_i) begin
            hdr_next = '0;
            hdr_next.req_type = write_i ? pcra_pkg::REQ_MEM_WR : pcra_pkg::REQ_MEM_RD;
            hdr_next.addr = addr_i[63:2];
            hdr_next.dword_count = dwords_i;
        end
        rcdw_next = rc_valid_i ? rc_hdr.dword_count : rcdw_reg;
        stat_next = set_vec | (stat_reg & enable_i);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hdr_reg <= '0;
            rcdw_reg <= '0;
            stat_reg <= '0;
        end else begin
            hdr_reg <= hdr_next;
            rcdw_reg <= rcdw_next;
            stat_reg <= stat_next;
        end
    end

    assign rq_hdr_o = hdr_reg;
    assign rc_dwords_o = rcdw_reg;
    assign status_o = stat_reg;
endmodule

// File: hdl/pcra_completer.sv
// Completer that serves register reads and writes from the request stream
`timescale 1ns/1ps
module pcra_completer (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [pcra_pkg::TDATA_W-1:0] cq_tdata_i,
    input wire logic cq_tvalid_i,
    input wire logic cq_tlast_i,
    output logic cq_tready_o,
    output logic [pcra_pkg::TDATA_W-1:0] cc_tdata_o,
    output logic [7:0] cc_tkeep_o,
    output logic cc_tvalid_o,
    output logic cc_tlast_o,
    input wire logic cc_tready_i,
    input wire logic [pcra_pkg::NUM_BARS-1:0][pcra_pkg::BAR_W-1:0] bar_i,
    input wire logic dma_req_i,
    input wire logic dma_write_i,
    input wire logic [63:0] dma_addr_i,
    input wire logic [10:0] dma_dwords_i,
    input wire logic [2:0] dma_desc_i,
    output logic [pcra_pkg::DESC_W-1:0] rq_hdr_o,
    input wire logic rc_valid_i,
    input wire logic [pcra_pkg::CC_DESC_W-1:0] rc_hdr_i,
    input wire logic [2:0] rc_desc_i,
    output logic [10:0] rc_dwords_o,
    output logic [pcra_pkg::NUM_DESC-1:0] desc_enable_o,
    output logic [pcra_pkg::NUM_DESC-1:0] desc_status_o
);
    pcra_pkg::pcra_state_e state_reg, state_next;
    pcra_pkg::pcra_cq_desc_s cq_desc;
    pcra_pkg::pcra_cq_desc_s desc_reg, desc_next;
    logic [pcra_pkg::REG_W-1:0] wdata_reg, wdata_next;
    logic [pcra_pkg::REG_W-1:0] fetch_reg, fetch_next;
    logic fetched_reg, fetched_next;
    logic sop_reg, sop_next;
    logic [pcra_pkg::TDATA_W-1:0] cc_data_reg, cc_data_next;
    logic [7:0] cc_keep_reg, cc_keep_next;
    logic cc_valid_reg, cc_valid_next;
    logic [2:0] err_status_reg, err_status_next;
    logic [pcra_pkg::NUM_BARS-1:0][pcra_pkg::BAR_W-1:0] bar_reg;
    logic reg_req_valid;
    pcra_pkg::pcra_reg_req_s reg_req;
    logic reg_done;
    logic [pcra_pkg::REG_W-1:0] reg_rdata;
    logic [pcra_pkg::REG_W-1:0] rd_aligned, pay_shifted, merged;
    logic [1:0] dw_off;
    logic [2:0] dw_end;
    logic [1:0] new_off;
    logic [2:0] new_end;
    logic cc_accept;

    // Builds one completion beat: 96-bit descriptor then dword-aligned payload
    function automatic logic [pcra_pkg::TDATA_W-1:0] build_cc(
            input pcra_pkg::pcra_cq_desc_s d, input logic [2:0] st,
            input logic [10:0] dw, input logic [pcra_pkg::REG_W-1:0] pl);
        pcra_pkg::pcra_cc_desc_s c;
        c = '0;
        c.attr = d.attr;
        c.tclass = d.tclass;
        c.tag = d.tag;
        c.requester_id = d.requester_id;
        c.status = st;
        c.dword_count = dw;
        c.byte_count = {dw, 2'b00};
        c.addr_type = d.addr_type;
        c.lower_addr = {d.addr[4:0], 2'b00};
        return {{(pcra_pkg::TDATA_W-pcra_pkg::REG_W-pcra_pkg::CC_DESC_W){1'b0}},
                pl, c};
    endfunction

    // Keeps the three descriptor dwords plus the payload dwords
    function automatic logic [7:0] keep_for(input logic [10:0] dw);
        logic [7:0] m;
        m = 8'((8'h01 << dw[2:0]) - 8'h01);
        return pcra_pkg::CC_DESC_KEEP | 8'(m << pcra_pkg::CC_DESC_DWORDS);
    endfunction

    assign cq_desc = cq_tdata_i[pcra_pkg::DESC_W-1:0];
    assign new_off = cq_desc.addr[1:0];
    assign new_end = {1'b0, new_off} + cq_desc.dword_count[2:0];
    assign dw_off = desc_reg.addr[1:0];
    assign dw_end = {1'b0, dw_off} + desc_reg.dword_count[2:0];
    assign rd_aligned = reg_rdata >> {dw_off, 5'b0};
    assign pay_shifted = wdata_reg << {dw_off, 5'b0};
    assign cc_accept = cc_valid_reg && cc_tready_i;

    // Partial write: only dwords covered by the request take new data
    genvar i;
    generate
        for (i = 0; i < pcra_pkg::REG_DWORDS; i++) begin : g_merge
            assign merged[i*32 +: 32] = (3'(i) >= {1'b0, dw_off} && 3'(i) < dw_end) ?
                pay_shifted[i*32 +: 32] : fetch_reg[i*32 +: 32];
        end
    endgenerate

    // Register map request is a level held until the fetch is answered or the completion is accepted
    always_comb begin
        reg_req = '0;
        reg_req.bar_id = desc_reg.bar_id;
        reg_req.addr = {desc_reg.addr, 2'b00};
        reg_req.write = state_reg == pcra_pkg::ST_MOD_WR;
        reg_req.wdata = merged;
        reg_req_valid = state_reg == pcra_pkg::ST_READ ||
                        state_reg == pcra_pkg::ST_MOD_WR ||
                        (state_reg == pcra_pkg::ST_WR_FETCH && !fetched_reg);
    end

    always_comb begin
        state_next = state_reg;
        desc_next = desc_reg;
        wdata_next = wdata_reg;
        fetch_next = fetch_reg;
        fetched_next = fetched_reg;
        sop_next = sop_reg;
        cc_data_next = cc_data_reg;
        cc_keep_next = cc_keep_reg;
        cc_valid_next = cc_valid_reg;
        err_status_next = err_status_reg;
        unique case (state_reg)
            pcra_pkg::ST_IDLE: begin
                // Beats after the first of a packet are drained and dropped
                if (cq_tvalid_i) begin
                    sop_next = cq_tlast_i;
                    if (sop_reg) begin
                        desc_next = cq_desc;
                        wdata_next = cq_tdata_i[pcra_pkg::TDATA_W-1:pcra_pkg::DESC_W];
                        fetched_next = 1'b0;
                        if (cq_desc.req_type != pcra_pkg::REQ_MEM_RD &&
                                cq_desc.req_type != pcra_pkg::REQ_MEM_WR &&
                                cq_desc.req_type != pcra_pkg::REQ_IO_RD &&
                                cq_desc.req_type != pcra_pkg::REQ_IO_WR) begin
                            err_status_next = pcra_pkg::CPL_UR;
                            state_next = pcra_pkg::ST_ERR_CPL;
                        end else if (cq_desc.dword_count > pcra_pkg::MAX_DWORDS ||
                                new_end > 3'(pcra_pkg::REG_DWORDS)) begin
                            err_status_next = pcra_pkg::CPL_CA;
                            state_next = pcra_pkg::ST_ERR_CPL;
                        end else if (cq_desc.req_type == pcra_pkg::REQ_MEM_RD ||
                                cq_desc.req_type == pcra_pkg::REQ_IO_RD) begin
                            state_next = pcra_pkg::ST_READ;
                        end else begin
                            state_next = pcra_pkg::ST_WR_FETCH;
                        end
                    end
                end
            end
            pcra_pkg::ST_READ: begin
                if (reg_done && !cc_valid_reg) begin
                    cc_data_next = build_cc(desc_reg, pcra_pkg::CPL_SC,
                                            desc_reg.dword_count, rd_aligned);
                    cc_keep_next = keep_for(desc_reg.dword_count);
                    cc_valid_next = 1'b1;
                end
                if (cc_accept) begin
                    cc_valid_next = 1'b0;
                    state_next = pcra_pkg::ST_WAIT;
                end
            end
            pcra_pkg::ST_WR_FETCH: begin
                if (reg_done && !fetched_reg) begin
                    fetch_next = reg_rdata;
                    fetched_next = 1'b1;
                end
                // A fresh done is needed for the write, so let this one fall first
                if (fetched_reg && !reg_done) begin
                    state_next = pcra_pkg::ST_MOD_WR;
                end
            end
            pcra_pkg::ST_MOD_WR: begin
                if (reg_done && !cc_valid_reg) begin
                    cc_data_next = build_cc(desc_reg, pcra_pkg::CPL_SC, '0, '0);
                    cc_keep_next = pcra_pkg::CC_DESC_KEEP;
                    cc_valid_next = 1'b1;
                end
                if (cc_accept) begin
                    cc_valid_next = 1'b0;
                    state_next = pcra_pkg::ST_WAIT;
                end
            end
            pcra_pkg::ST_WAIT: begin
                if (!reg_done) begin
                    state_next = pcra_pkg::ST_IDLE;
                end
            end
            pcra_pkg::ST_ERR_CPL: begin
                if (!cc_valid_reg) begin
                    cc_data_next = build_cc(desc_reg, err_status_reg, '0, '0);
                    cc_keep_next = pcra_pkg::CC_DESC_KEEP;
                    cc_valid_next = 1'b1;
                end
                if (cc_accept) begin
                    cc_valid_next = 1'b0;
                    state_next = pcra_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = pcra_pkg::ST_IDLE;
                cc_valid_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_reg <= pcra_pkg::ST_IDLE;
            desc_reg <= '0;
            wdata_reg <= '0;
            fetch_reg <= '0;
            fetched_reg <= 1'b0;
            sop_reg <= 1'b1;
            cc_data_reg <= '0;
            cc_keep_reg <= '0;
            cc_valid_reg <= 1'b0;
            err_status_reg <= pcra_pkg::CPL_SC;
            bar_reg <= '0;
        end else begin
            state_reg <= state_next;
            desc_reg <= desc_next;
            wdata_reg <= wdata_next;
            fetch_reg <= fetch_next;
            fetched_reg <= fetched_next;
            sop_reg <= sop_next;
            cc_data_reg <= cc_data_next;
            cc_keep_reg <= cc_keep_next;
            cc_valid_reg <= cc_valid_next;
            err_status_reg <= err_status_next;
            bar_reg <= bar_i;
        end
    end

    assign cq_tready_o = state_reg == pcra_pkg::ST_IDLE;
    assign cc_tdata_o = cc_data_reg;
    assign cc_tkeep_o = cc_keep_reg;
    assign cc_tvalid_o = cc_valid_reg;
    assign cc_tlast_o = cc_valid_reg;

    pcra_reg_map u_reg_map (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .req_valid_i(reg_req_valid),
        .req_i(reg_req),
        .bar_i(bar_reg),
        .desc_status_i(desc_status_o),
        .done_o(reg_done),
        .rdata_o(reg_rdata),
        .desc_enable_o(desc_enable_o)
    );

    pcra_dma_hdr u_dma_hdr (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .req_i(dma_req_i),
        .write_i(dma_write_i),
        .addr_i(dma_addr_i),
        .dwords_i(dma_dwords_i),
        .desc_i(dma_desc_i),
        .enable_i(desc_enable_o),
        .rc_valid_i(rc_valid_i),
        .rc_hdr_i(rc_hdr_i),
        .rc_desc_i(rc_desc_i),
        .rq_hdr_o(rq_hdr_o),
        .rc_dwords_o(rc_dwords_o),
        .status_o(desc_status_o)
    );
endmodule

// File: sim/pcra_checker.sv
// Port assertions of the completer
`timescale 1ns/1ps
module pcra_checker (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic cq_tvalid_i,
    input wire logic cq_tready_o,
    input wire logic cc_tvalid_o,
    input wire logic cc_tready_i,
    input wire logic cc_tlast_o,
    input wire logic [pcra_pkg::TDATA_W-1:0] cc_tdata_o,
    input wire logic dma_req_i,
    input wire logic dma_write_i,
    input wire logic [63:0] dma_addr_i,
    input wire logic [10:0] dma_dwords_i,
    input wire logic [pcra_pkg::DESC_W-1:0] rq_hdr_o,
    input wire logic rc_valid_i,
    input wire logic [pcra_pkg::CC_DESC_W-1:0] rc_hdr_i,
    input wire logic [10:0] rc_dwords_o,
    input wire logic [2:0] dma_desc_i,
    input wire logic [2:0] rc_desc_i,
    input wire logic [pcra_pkg::NUM_DESC-1:0] desc_enable_o,
    input wire logic [pcra_pkg::NUM_DESC-1:0] desc_status_o
);
    logic [10:0] rc_cnt;
    assign rc_cnt = rc_hdr_i[42:32];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    sequence take_s; cq_tvalid_i && cq_tready_o; endsequence
    sequence done_s; cc_tvalid_o && cc_tready_i; endsequence
    chk_ready_low: assert property (take_s |=> !cq_tready_o)
        else $error("request ready stayed high after a take");
    chk_serve_bound: assert property (take_s |-> ##[2:80] cc_tvalid_o)
        else $error("no completion after a request");
    chk_ready_back: assert property (done_s |=> !cc_tvalid_o ##[0:40] cq_tready_o)
        else $error("idle not reached after completion");
    chk_cc_hold: assert property (cc_tvalid_o && !cc_tready_i |=> cc_tvalid_o && $stable(cc_tdata_o))
        else $error("completion changed before acceptance");
    chk_last_single: assert property (cc_tlast_o == cc_tvalid_o)
        else $error("completion is not a single beat");
    chk_rq_type: assert property (dma_req_i |=> rq_hdr_o[78:75] == {3'h0, $past(dma_write_i)})
        else $error("request type wrong");
    chk_rq_fields: assert property (dma_req_i |=> rq_hdr_o[127:79] == '0 &&
        rq_hdr_o[74:0] == {$past(dma_dwords_i), $past(dma_addr_i) & 64'hffff_ffff_ffff_fffc})
        else $error("request header fields wrong");
    chk_rc_strip: assert property (rc_valid_i |=> rc_dwords_o == $past(rc_cnt))
        else $error("stripped dword count wrong");
    chk_status_set: assert property (dma_req_i && dma_write_i |=>
        desc_status_o[$past(dma_desc_i)])
        else $error("descriptor status not set by request");
    chk_status_rc: assert property (rc_valid_i |=> desc_status_o[$past(rc_desc_i)])
        else $error("descriptor status not set by completion");
    chk_status_clear: assert property (!(dma_req_i && dma_write_i) && !rc_valid_i &&
        desc_enable_o == '0 |=> desc_status_o == '0)
        else $error("disabled descriptor status not cleared");
endmodule

// File: sim/pcra_host_model.sv
// Host side that accepts completions and stalls at random
`timescale 1ns/1ps
module pcra_host_model (
    input wire logic clk_i,
    output logic cc_tready_i
);
    int seed = 71543;
    always @(posedge clk_i) begin
        #1 cc_tready_i = ($random(seed) % 4) != 0;
    end
endmodule

// File: sim/pcie_completer_register_access_bench.sv
// Self-checking bench of the completer
`timescale 1ns/1ps
module pcie_completer_register_access_bench;
    typedef struct packed {logic [2:0] st; logic [7:0] tag; logic [127:0] d, m;} pcra_exp_s;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [255:0] cq_tdata_i = '0, cc_tdata_o;
    logic cq_tvalid_i = 1'b0, cq_tlast_i = 1'b1, dma_req_i = 1'b0, dma_write_i = 1'b0;
    logic cq_tready_o, cc_tvalid_o, cc_tlast_o, cc_tready_i, rc_valid_i = 1'b0;
    logic [7:0] cc_tkeep_o, desc_enable_o, desc_status_o, kp, tag = '0;
    logic [2:0][31:0] bar_i = {32'h0, 32'h0, 32'h0001_0000};
    logic [63:0] dma_addr_i = '0;
    logic [10:0] dma_dwords_i = '0, rc_dwords_o;
    logic [2:0] dma_desc_i = '0, rc_desc_i = '0;
    logic [95:0] rc_hdr_i = '0;
    logic [127:0] rq_hdr_o, wd, mirror [16];
    pcra_exp_s exp_q [$], e_mon;
    int seed = 71543, error_cnt = 0, checks = 0, k;
    pcra_completer i_dut (.*);
    pcra_host_model i_host (.clk_i(clk_i), .cc_tready_i(cc_tready_i));
    always #12.5 clk_i = ~clk_i;
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic send(input logic [3:0] ty, input logic [7:0] off, input logic [10:0] n,
            input logic [2:0] st);
        pcra_pkg::pcra_cq_desc_s d;
        pcra_exp_s e;
        logic [63:0] a;
        int i;
        wd = {$random(seed), $random(seed), $random(seed), $random(seed)};
        a = {32'h0, bar_i[0] + {24'h0, off}};
        d = '0;
        d.addr = a[63:2];
        d.dword_count = n;
        d.req_type = ty;
        d.requester_id = 16'($random(seed));
        d.tag = tag;
        e = '{st, tag, '0, '0};
        for (i = 0; i < 4; i++) begin
            if (i < n && st == pcra_pkg::CPL_SC) begin
                e.m[32*i+:32] = '1;
                if (ty[0]) mirror[off[7:4]][32*(off[3:2]+i)+:32] = wd[32*i+:32];
            end
        end
        e.d = mirror[off[7:4]] >> (32 * off[3:2]);
        if (ty[0]) e.m = '0;
        tag++;
        exp_q.push_back(e);
        cq_tdata_i = {wd, d};
        cq_tvalid_i = 1'b1;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (cq_tready_o !== 1'b1 && i < 200);
        #1 cq_tvalid_i = 1'b0;
        for (k = 0; k < 300 && exp_q.size() > 0; k++) @(posedge clk_i);
        if (i >= 200 || exp_q.size() > 0) begin
            error_cnt++;
            print_verdict();
        end
        #1;
    endtask
    always @(posedge clk_i) begin
        if (cc_tvalid_o === 1'b1 && cc_tready_i === 1'b1) begin
            if (exp_q.size() > 0) e_mon = exp_q.pop_front();
            else e_mon = '{3'h7, 8'h0, '0, '0};
            // Keep holds the three descriptor dwords plus one bit per returned dword
            kp = {1'b0, e_mon.m[96], e_mon.m[64], e_mon.m[32], e_mon.m[0], 3'h7};
            check("status", 128'(cc_tdata_o[45:43]), 128'(e_mon.st));
            check("tag", 128'(cc_tdata_o[71:64]), 128'(e_mon.tag));
            check("data", cc_tdata_o[223:96] & e_mon.m, e_mon.d & e_mon.m);
            check("keep", 128'(cc_tkeep_o), 128'(kp));
        end
        if (!srst_i) begin
            #1 {dma_req_i, dma_write_i, dma_desc_i, rc_valid_i, rc_desc_i} = 9'($random(seed));
            dma_addr_i = {$random(seed), $random(seed)};
            dma_dwords_i = 11'($random(seed));
            rc_hdr_i = {$random(seed), $random(seed), $random(seed)};
        end
    end
    initial begin
        foreach (mirror[j]) mirror[j] = '0;
        repeat (12) @(posedge clk_i);
        #1 srst_i = 1'b0;
        send(pcra_pkg::REQ_MEM_WR, 8'h10, 11'h4, pcra_pkg::CPL_SC);
        send(pcra_pkg::REQ_MEM_RD, 8'h10, 11'h4, pcra_pkg::CPL_SC);
        send(pcra_pkg::REQ_IO_WR, 8'h18, 11'h1, pcra_pkg::CPL_SC);
        send(pcra_pkg::REQ_IO_RD, 8'h14, 11'h2, pcra_pkg::CPL_SC);
        $display("test read and write done");
        for (int t = 4; t < 16; t++) send(4'(t), 8'h30, 11'h1, pcra_pkg::CPL_UR);
        send(pcra_pkg::REQ_MEM_WR, 8'h20, 11'h5, pcra_pkg::CPL_CA);
        send(pcra_pkg::REQ_MEM_WR, 8'h2c, 11'h2, pcra_pkg::CPL_CA);
        send(pcra_pkg::REQ_MEM_RD, 8'h20, 11'h4, pcra_pkg::CPL_SC);
        $display("test refused requests done");
        send(pcra_pkg::REQ_MEM_WR, 8'hf0, 11'h1, pcra_pkg::CPL_SC);
        for (k = 0; k < 40 && desc_enable_o !== wd[7:0]; k++) @(posedge clk_i);
        check("enable", 128'(desc_enable_o), 128'(wd[7:0]));
        $display("test descriptor enable done");
        print_verdict();
    end
endmodule
bind pcra_completer pcra_checker i_chk (.*);
